// ==== design/policy_defs.svh ====
// constants for the mode response and cable reset policy block
`ifndef POLICY_DEFS_SVH
`define POLICY_DEFS_SVH

// ****************************************
// widths
// ****************************************
`define MODE_W 8
`define NAK_CODE_W 2

// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 25
// time the plug holds its full reset before reporting completion
`define CBL_RESET_NS 1000
`define CBL_RESET_CYC ((`CBL_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CBL_RESET_CNT_W 7

`endif

// ==== design/policy_pkg.sv ====
// types shared by the mode response and cable reset policy block
`include "policy_defs.svh"

package policy_pkg;

   // ****************************************
   // engine states
   // ****************************************
   typedef enum logic [3:0] {
      ST_SRC_READY  = 4'b0000,
      ST_SNK_READY  = 4'b0001,
      ST_EVAL_ENTRY = 4'b0010,
      ST_ENTRY_ACK  = 4'b0011,
      ST_ENTRY_NAK  = 4'b0100,
      ST_MODE_EXIT  = 4'b0101,
      ST_EXIT_ACK   = 4'b0110,
      ST_EXIT_NAK   = 4'b0111,
      ST_CBL_READY  = 4'b1000,
      ST_CBL_SOFT   = 4'b1001,
      ST_CBL_HARD   = 4'b1010
   } pe_state_e;

   // ****************************************
   // carriers
   // ****************************************
   // structured enter or exit mode request from the far port
   typedef struct packed {
      logic valid;
      logic is_exit;
      logic [`MODE_W-1:0] mode;
   } mode_cmd_s;

   // verdict from the device policy manager
   typedef struct packed {
      logic entered;
      logic left;
      logic nak;
      logic [`NAK_CODE_W-1:0] nak_code;
   } dpm_rsp_s;

   // request to the device policy manager
   typedef struct packed {
      logic enter_eval;
      logic exit_req;
      logic [`MODE_W-1:0] mode;
   } dpm_req_s;

   // response handed to the protocol layer for transmission
   typedef struct packed {
      logic valid;
      logic is_exit;
      logic ack;
      logic [`NAK_CODE_W-1:0] nak_code;
      logic [`MODE_W-1:0] mode;
   } mode_rsp_s;

   // events reported by the protocol layer
   typedef struct packed {
      logic soft_reset_rx;
      logic hard_reset_rx;
      logic cable_reset_rx;
      logic tx_sent;
      logic tx_err;
   } prl_evt_s;

endpackage : policy_pkg

// ==== design/cable_reset_timer.sv ====
// timer that paces the cable plug's full reset
`timescale 1ns/1ps
`include "policy_defs.svh"

module cable_reset_timer (
   // clock and reset
   input logic clk,
   input logic rstn,
   // control
   input logic start,
   output logic busy,
   output logic done
);

   localparam int RESET_CYC_I = `CBL_RESET_CYC;

   logic [`CBL_RESET_CNT_W-1:0] count_reg;
   logic [`CBL_RESET_CNT_W-1:0] count_next;
   logic done_reg;
   logic done_next;
   logic [`CBL_RESET_CNT_W-1:0] elapsed_reg;

   // ****************************************
   // countdown
   // ****************************************
   always_comb begin
      count_next = count_reg;
      done_next = 1'b0;
      if (!rstn) begin
         count_next = '0;
      end else if (start) begin
         count_next = `CBL_RESET_CNT_W'(`CBL_RESET_CYC);
      end else if (count_reg != '0) begin
         count_next = count_reg - `CBL_RESET_CNT_W'(1);
         done_next = (count_reg == `CBL_RESET_CNT_W'(1));
      end
   end

   always_ff @(posedge clk) begin
      count_reg <= count_next;
      done_reg <= done_next;
   end

   assign busy = (count_reg != '0);
   assign done = done_reg;

   // ****************************************
   // checks
   // ****************************************
   // cycles since the last start, for the check only
   always_ff @(posedge clk) begin
      if (!rstn || start) begin
         elapsed_reg <= '0;
      end else if (elapsed_reg != '1) begin
         elapsed_reg <= elapsed_reg + `CBL_RESET_CNT_W'(1);
      end
   end

   reset_length_a: assert property (
      @(posedge clk) disable iff (!rstn)
      done |-> (int'(elapsed_reg) == RESET_CYC_I))
      else $error("full reset completed after wrong number of cycles");

endmodule : cable_reset_timer

// ==== design/mode_reset_policy.sv ====
// mode entry/exit responder and cable plug reset engine
`timescale 1ns/1ps
`include "policy_defs.svh"

module mode_reset_policy
   import policy_pkg::*;
(
   // clock and reset
   input logic clk,
   input logic rstn,
   // role
   input logic cable_role,
   input logic power_src,
   // far port requests and protocol layer events
   input mode_cmd_s cmd,
   input prl_evt_s prl,
   // device policy manager
   output dpm_req_s dpm_req,
   input dpm_rsp_s dpm_rsp,
   // protocol layer requests
   output mode_rsp_s rsp,
   output logic prl_reset,
   output logic accept_tx,
   // plug and status
   output logic full_reset,
   output logic mode_active,
   output pe_state_e state
);

   // ****************************************
   // helpers
   // ****************************************
   function automatic pe_state_e ready_state(input logic cable, input logic src);
      if (cable) begin
         ready_state = ST_CBL_READY;
      end else if (src) begin
         ready_state = ST_SRC_READY;
      end else begin
         ready_state = ST_SNK_READY;
      end
   endfunction : ready_state

   function automatic logic is_tx_state(input pe_state_e s);
      is_tx_state = (s == ST_ENTRY_ACK) || (s == ST_ENTRY_NAK) ||
                    (s == ST_EXIT_ACK) || (s == ST_EXIT_NAK);
   endfunction : is_tx_state

   // ****************************************
   // state
   // ****************************************
   pe_state_e state_reg;
   pe_state_e state_next;
   logic [`MODE_W-1:0] mode_reg;
   logic [`MODE_W-1:0] mode_next;
   logic [`NAK_CODE_W-1:0] nak_code_reg;
   logic [`NAK_CODE_W-1:0] nak_code_next;
   logic accept_wait_reg;
   logic accept_wait_next;
   logic modal_reg;
   logic modal_next;
   dpm_req_s dpm_req_reg;
   dpm_req_s dpm_req_next;
   mode_rsp_s rsp_reg;
   mode_rsp_s rsp_next;
   logic prl_reset_reg;
   logic prl_reset_next;
   logic accept_tx_reg;
   logic accept_tx_next;
   logic full_reset_reg;
   logic full_reset_next;

   logic soft_evt;
   logic hard_evt;
   logic hard_start;
   logic timer_done;

   assign hard_evt = cable_role && (prl.hard_reset_rx || prl.cable_reset_rx);
   assign soft_evt = cable_role && prl.soft_reset_rx && !hard_evt;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      state_next = state_reg;
      mode_next = mode_reg;
      nak_code_next = nak_code_reg;
      accept_wait_next = accept_wait_reg;
      modal_next = modal_reg;
      case (state_reg)
         ST_SRC_READY, ST_SNK_READY: begin
            if (cmd.valid && !cable_role) begin
               mode_next = cmd.mode;
               if (cmd.is_exit) begin
                  state_next = ST_MODE_EXIT;
               end else begin
                  state_next = ST_EVAL_ENTRY;
               end
            end else begin
               state_next = ready_state(cable_role, power_src);
            end
         end
         ST_EVAL_ENTRY: begin
            if (dpm_rsp.entered) begin
               state_next = ST_ENTRY_ACK;
               modal_next = 1'b1;
            end else if (dpm_rsp.nak) begin
               state_next = ST_ENTRY_NAK;
               nak_code_next = dpm_rsp.nak_code;
            end
         end
         ST_MODE_EXIT: begin
            if (dpm_rsp.left) begin
               state_next = ST_EXIT_ACK;
               modal_next = 1'b0;
            end else if (dpm_rsp.nak) begin
               state_next = ST_EXIT_NAK;
               nak_code_next = dpm_rsp.nak_code;
            end
         end
         ST_ENTRY_ACK, ST_ENTRY_NAK, ST_EXIT_ACK, ST_EXIT_NAK: begin
            // a failed send also gives up the response and returns home
            if (prl.tx_sent || prl.tx_err) begin
               state_next = ready_state(cable_role, power_src);
            end
         end
         ST_CBL_READY: begin
            state_next = ready_state(cable_role, power_src);
         end
         ST_CBL_SOFT: begin
            if (!accept_wait_reg) begin
               accept_wait_next = 1'b1;
            end else if (prl.tx_sent) begin
               state_next = ST_CBL_READY;
            end else if (prl.tx_err) begin
               state_next = ST_CBL_HARD;
            end
         end
         ST_CBL_HARD: begin
            if (timer_done) begin
               state_next = ST_CBL_READY;
            end
         end
         default: begin
            state_next = ready_state(cable_role, power_src);
         end
      endcase
      if (soft_evt) begin
         state_next = ST_CBL_SOFT;
         accept_wait_next = 1'b0;
      end
      if (hard_evt) begin
         state_next = ST_CBL_HARD;
      end
      if (state_next == ST_CBL_HARD) begin
         modal_next = 1'b0;
      end
      if (!rstn) begin
         state_next = ready_state(cable_role, power_src);
         mode_next = '0;
         nak_code_next = '0;
         accept_wait_next = 1'b0;
         modal_next = 1'b0;
      end
   end

   // ****************************************
   // registered outputs
   // ****************************************
   assign hard_start = rstn && (hard_evt ||
                       (state_next == ST_CBL_HARD && state_reg != ST_CBL_HARD));

   always_comb begin
      dpm_req_next.enter_eval = (state_next == ST_EVAL_ENTRY) &&
                                (state_reg != ST_EVAL_ENTRY);
      dpm_req_next.exit_req = (state_next == ST_MODE_EXIT) &&
                              (state_reg != ST_MODE_EXIT);
      dpm_req_next.mode = mode_next;
      rsp_next.valid = is_tx_state(state_next) && (state_next != state_reg);
      rsp_next.is_exit = (state_next == ST_EXIT_ACK) || (state_next == ST_EXIT_NAK);
      rsp_next.ack = (state_next == ST_ENTRY_ACK) || (state_next == ST_EXIT_ACK);
      rsp_next.nak_code = nak_code_next;
      rsp_next.mode = mode_next;
      prl_reset_next = (state_next == ST_CBL_SOFT) && !accept_wait_next;
      accept_tx_next = (state_next == ST_CBL_SOFT) && accept_wait_next &&
                       !accept_wait_reg;
      full_reset_next = (state_next == ST_CBL_HARD);
      if (!rstn) begin
         dpm_req_next = '0;
         rsp_next = '0;
         prl_reset_next = 1'b0;
         accept_tx_next = 1'b0;
         full_reset_next = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      nak_code_reg <= nak_code_next;
      accept_wait_reg <= accept_wait_next;
      modal_reg <= modal_next;
      dpm_req_reg <= dpm_req_next;
      rsp_reg <= rsp_next;
      prl_reset_reg <= prl_reset_next;
      accept_tx_reg <= accept_tx_next;
      full_reset_reg <= full_reset_next;
   end

   assign dpm_req = dpm_req_reg;
   assign rsp = rsp_reg;
   assign prl_reset = prl_reset_reg;
   assign accept_tx = accept_tx_reg;
   assign full_reset = full_reset_reg;
   assign mode_active = modal_reg;
   assign state = state_reg;

   // ****************************************
   // full reset pacing
   // ****************************************
   cable_reset_timer u_reset_timer (
      .clk(clk),
      .rstn(rstn),
      .start(hard_start),
      .busy(),
      .done(timer_done)
   );

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   enter_goes_eval_a: assert property (
      (state_reg inside {ST_SRC_READY, ST_SNK_READY}) && cmd.valid && !cmd.is_exit &&
      !cable_role |=> state_reg == ST_EVAL_ENTRY)
      else $error("enter request did not reach evaluation");

   eval_asks_dpm_a: assert property (
      (state_reg == ST_EVAL_ENTRY) && ($past(state_reg) != ST_EVAL_ENTRY) |->
      dpm_req.enter_eval && (dpm_req.mode == mode_reg) ##1 !dpm_req.enter_eval)
      else $error("evaluation entry without single manager request");

   entry_ack_go_a: assert property (
      (state_reg == ST_EVAL_ENTRY) && dpm_rsp.entered && !cable_role |=>
      (state_reg == ST_ENTRY_ACK) && mode_active)
      else $error("mode entered but no entry acknowledge");

   entry_nak_go_a: assert property (
      (state_reg == ST_EVAL_ENTRY) && !dpm_rsp.entered && dpm_rsp.nak && !cable_role
      |=> (state_reg == ST_ENTRY_NAK) && (rsp.nak_code == $past(dpm_rsp.nak_code)))
      else $error("entry nak not taken");

   entry_ack_send_a: assert property (
      (state_reg == ST_ENTRY_ACK) && ($past(state_reg) == ST_EVAL_ENTRY) |->
      rsp.valid && rsp.ack && !rsp.is_exit)
      else $error("enter ack not requested");

   nak_return_a: assert property (
      (state_reg inside {ST_ENTRY_NAK, ST_EXIT_NAK}) && prl.tx_sent && !cable_role |->
      !rsp.ack ##1 (state_reg inside {ST_SRC_READY, ST_SNK_READY}))
      else $error("nak state did not return to ready");

   exit_goes_a: assert property (
      (state_reg inside {ST_SRC_READY, ST_SNK_READY}) && cmd.valid && cmd.is_exit &&
      !cable_role |=> (state_reg == ST_MODE_EXIT) && dpm_req.exit_req &&
      (dpm_req.mode == $past(cmd.mode)))
      else $error("exit request not handed to manager");

   exit_ack_go_a: assert property (
      (state_reg == ST_MODE_EXIT) && dpm_rsp.left && !cable_role |=>
      state_reg == ST_EXIT_ACK)
      else $error("mode left but no exit acknowledge");

   exit_nak_go_a: assert property (
      (state_reg == ST_MODE_EXIT) && !dpm_rsp.left && dpm_rsp.nak && !cable_role |=>
      state_reg == ST_EXIT_NAK)
      else $error("exit nak not taken");

   exit_ack_send_a: assert property (
      (state_reg == ST_EXIT_ACK) && ($past(state_reg) == ST_MODE_EXIT) |->
      rsp.valid && rsp.ack && rsp.is_exit)
      else $error("exit ack not requested");

   exit_clears_modal_a: assert property (
      (state_reg == ST_EXIT_ACK) |-> !mode_active)
      else $error("still modal after exit acknowledge");

   home_after_reset_a: assert property (
      @(posedge clk) disable iff (1'b0)
      !rstn && cable_role |=> state_reg == ST_CBL_READY)
      else $error("plug did not start in cable ready");

   soft_entry_a: assert property (
      soft_evt |=> (state_reg == ST_CBL_SOFT) && prl_reset)
      else $error("soft reset message not honoured");

   reset_then_accept_a: assert property (
      prl_reset && !soft_evt && !hard_evt |=> accept_tx && !prl_reset)
      else $error("accept not requested after protocol reset");

   soft_err_hard_a: assert property (
      (state_reg == ST_CBL_SOFT) && accept_wait_reg && prl.tx_err && !prl.tx_sent &&
      cable_role && !prl.soft_reset_rx |=> state_reg == ST_CBL_HARD)
      else $error("transmit error did not force hard reset");

   hard_entry_a: assert property (
      hard_evt |=> (state_reg == ST_CBL_HARD) && full_reset)
      else $error("hard or cable reset signaling not honoured");

   hard_done_a: assert property (
      (state_reg == ST_CBL_HARD) && timer_done && !hard_evt && !soft_evt |=>
      (state_reg == ST_CBL_READY) && !full_reset)
      else $error("plug did not return after full reset");

   role_ready_a: assert property (
      is_tx_state(state_reg) && prl.tx_sent && !cable_role |=>
      state_reg == ($past(power_src) ? ST_SRC_READY : ST_SNK_READY))
      else $error("returned to ready of wrong power role");

endmodule : mode_reset_policy

// ==== verification/far_port.sv ====
// far port and protocol layer model facing the policy block
`timescale 1ns/1ps

module far_port
   import policy_pkg::*;
#(
   parameter int RSP_TO = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // bench controls
   input wire logic start_soft,
   input wire logic start_hard,
   input wire logic start_cable,
   input wire logic err_en,
   input wire logic [3:0] dly,
   // block side
   input wire logic rsp_valid,
   input wire logic accept_tx,
   output prl_evt_s prl
);
   logic [3:0] send_cnt;
   logic send_pend;
   logic [5:0] rsp_tmr;
   logic tmr_run;

   always_ff @(posedge clk) begin
      prl <= '0;
      if (!rstn) begin
         send_pend <= 1'b0;
         send_cnt <= 4'h0;
         tmr_run <= 1'b0;
         rsp_tmr <= 6'h00;
      end else begin
         // a transmission completes a chosen number of cycles later
         if (rsp_valid || accept_tx) begin
            send_pend <= 1'b1;
            send_cnt <= dly;
         end else if (send_pend && send_cnt != 4'h0) begin
            send_cnt <= send_cnt - 4'h1;
         end else if (send_pend) begin
            send_pend <= 1'b0;
            prl.tx_sent <= !err_en;
            prl.tx_err <= err_en;
            if (!err_en) tmr_run <= 1'b0;
         end
         if (start_soft) begin
            prl.soft_reset_rx <= 1'b1;
            tmr_run <= 1'b1;
            rsp_tmr <= RSP_TO[5:0];
         end else if (tmr_run && rsp_tmr != 6'h00) begin
            rsp_tmr <= rsp_tmr - 6'h01;
         end else if (tmr_run) begin
            tmr_run <= 1'b0;
            prl.cable_reset_rx <= 1'b1;
         end
         if (start_hard) prl.hard_reset_rx <= 1'b1;
         if (start_cable) prl.cable_reset_rx <= 1'b1;
      end
   end
endmodule : far_port

// ==== verification/tb.sv ====
// self-checking bench for the mode response and cable reset policy block
`timescale 1ns/1ps
`include "policy_defs.svh"

module tb;
   import policy_pkg::*;
   localparam int HARD_LEN = `CBL_RESET_CYC + 1;
   logic clk;
   logic rstn = 1'b0;
   logic cable_role = 1'b0;
   logic power_src = 1'b1;
   mode_cmd_s cmd = '0;
   dpm_rsp_s dpm_rsp = '0;
   logic start_soft = 1'b0;
   logic start_hard = 1'b0;
   logic start_cable = 1'b0;
   logic err_en = 1'b0;
   logic [3:0] dly = 4'h0;
   prl_evt_s prl;
   dpm_req_s dpm_req;
   mode_rsp_s rsp;
   logic prl_reset;
   logic accept_tx;
   logic full_reset;
   logic mode_active;
   pe_state_e state;
   logic act_exp;
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;

   mode_reset_policy i_dut (.clk(clk), .rstn(rstn), .cable_role(cable_role),
      .power_src(power_src), .cmd(cmd), .prl(prl), .dpm_req(dpm_req), .dpm_rsp(dpm_rsp),
      .rsp(rsp), .prl_reset(prl_reset), .accept_tx(accept_tx), .full_reset(full_reset),
      .mode_active(mode_active), .state(state));

   far_port #(.RSP_TO(20)) i_far (.clk(clk), .rstn(rstn), .start_soft(start_soft),
      .start_hard(start_hard), .start_cable(start_cable), .err_en(err_en), .dly(dly),
      .rsp_valid(rsp.valid), .accept_tx(accept_tx), .prl(prl));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         test_done();
      end
   end

   // ****************************************
   // helpers
   // ****************************************
   function automatic pe_state_e ready_of(input logic cab, input logic src);
      if (cab) return ST_CBL_READY;
      return src ? ST_SRC_READY : ST_SNK_READY;
   endfunction : ready_of

   function automatic pe_state_e send_of(input logic ex, input logic ack);
      if (ex) return ack ? ST_EXIT_ACK : ST_EXIT_NAK;
      return ack ? ST_ENTRY_ACK : ST_ENTRY_NAK;
   endfunction : send_of

   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk);
      #2;
   endtask : tick

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic wait_state(input pe_state_e s);
      int n;
      n = 0;
      while (state !== s && n < 300) begin
         tick();
         n++;
      end
      chk("state reached", 16'(s), 16'(state));
   endtask : wait_state

   task automatic do_reset(input logic role, input logic src);
      rstn = 1'b0;
      cable_role = role;
      power_src = src;
      tick(5);
      chk("state in reset", 16'(ready_of(role, src)), 16'(state));
      chk("mode active in reset", 16'h0000, 16'(mode_active));
      rstn = 1'b1;
      act_exp = 1'b0;
      tick();
   endtask : do_reset

   task automatic mode_txn(input logic ex, input logic ack, input logic [1:0] code,
      input logic [7:0] m, input int wt);
      cmd = '{valid: 1'b1, is_exit: ex, mode: m};
      tick();
      cmd.valid = 1'b0;
      chk("eval state", 16'(ex ? ST_MODE_EXIT : ST_EVAL_ENTRY), 16'(state));
      chk("manager request", 16'({!ex, ex, m}), 16'(dpm_req));
      cmd = '{valid: 1'b1, is_exit: !ex, mode: ~m};
      tick();
      cmd.valid = 1'b0;
      tick(wt);
      chk("busy request ignored", 16'({2'b00, m}), 16'(dpm_req));
      dpm_rsp = '{entered: ack && !ex, left: ack && ex, nak: !ack, nak_code: code};
      tick();
      dpm_rsp = '0;
      chk("send state", 16'(send_of(ex, ack)), 16'(state));
      chk("response", 16'({1'b1, ex, ack, m}),
         16'({rsp.valid, rsp.is_exit, rsp.ack, rsp.mode}));
      if (!ack) chk("nak code", 16'(code), 16'(rsp.nak_code));
      if (ack) act_exp = !ex;
      chk("mode active", 16'(act_exp), 16'(mode_active));
      wait_state(ready_of(1'b0, power_src));
      chk("mode active in ready", 16'(act_exp), 16'(mode_active));
   endtask : mode_txn

   task automatic hard_run(output int n);
      n = 0;
      while (state === ST_CBL_HARD && n < 400) begin
         chk("full reset", 16'h0001, 16'(full_reset));
         tick();
         n++;
      end
      chk("state after hard", 16'(ST_CBL_READY), 16'(state));
      chk("full reset released", 16'h0000, 16'(full_reset));
   endtask : hard_run

   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : test_done

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      int n;
      logic ex;
      logic ack;
      int wt;
      void'($urandom(32'h874a_fdcc));
      do_reset(1'b0, 1'b1);
      for (int i = 0; i < 24; i++) begin
         ex = (i < 2) ? i[0] : 1'($urandom_range(0, 1));
         ack = (i < 2) ? 1'b1 : 1'($urandom_range(0, 1));
         power_src = 1'($urandom_range(0, 1));
         dly = (i < 2) ? 4'h0 : 4'($urandom_range(0, 5));
         // a failed response send must also bring the responder home
         err_en = (i >= 2) && ($urandom_range(0, 3) == 0);
         wt = (i < 2) ? 0 : $urandom_range(0, 4);
         mode_txn(ex, ack, 2'($urandom_range(0, 3)), 8'($urandom), wt);
      end
      do_reset(1'b1, 1'b0);
      cmd = '{valid: 1'b1, is_exit: 1'b0, mode: 8'h5a};
      tick();
      cmd.valid = 1'b0;
      tick();
      chk("plug ignores mode request", 16'(ST_CBL_READY), 16'(state));
      for (int k = 0; k < 4; k++) begin
         err_en = (k == 3);
         dly = 4'($urandom_range(0, 5));
         start_soft = 1'b1;
         tick();
         start_soft = 1'b0;
         tick();
         chk("soft state", 16'(ST_CBL_SOFT), 16'(state));
         chk("layer reset first", 16'h0002, 16'({prl_reset, accept_tx}));
         tick();
         chk("accept request", 16'h0001, 16'({prl_reset, accept_tx}));
         wait_state(err_en ? ST_CBL_HARD : ST_CBL_READY);
      end
      hard_run(n);
      chk("restarted hard reset", 16'h0001, 16'(n > HARD_LEN));
      err_en = 1'b0;
      for (int k = 0; k < 2; k++) begin
         start_hard = (k == 0);
         start_cable = (k == 1);
         tick();
         start_hard = 1'b0;
         start_cable = 1'b0;
         tick();
         chk("hard state", 16'(ST_CBL_HARD), 16'(state));
         hard_run(n);
         chk("hard reset length", 16'(HARD_LEN), 16'(n));
      end
      start_hard = 1'b1;
      tick();
      start_hard = 1'b0;
      tick(10);
      start_soft = 1'b1;
      tick();
      start_soft = 1'b0;
      tick();
      chk("soft during hard", 16'(ST_CBL_SOFT), 16'(state));
      wait_state(ST_CBL_READY);
      test_done();
   end
endmodule : tb
